// *** rtl/sdw_pin_if.sv ***
// Interface carrying the synchronised serial pins.
`timescale 1ns/10ps
interface sdw_pin_if;
  logic sclk;
  logic cs_n;
  logic din;
  logic sel;
  modport src (output sclk, output cs_n, output din, output sel);
  modport snk (input sclk, input cs_n, input din, input sel);
endinterface

// *** rtl/sdw_pkg.sv ***
// Constants shared by the serial converter write port.
package sdw_pkg;
  // Frame layout: sixteen bits, most significant bit first.
  localparam int FRAME_BITS = 16;
  localparam logic [4:0] FRAME_BITS_C = 5'h10;
  localparam logic [4:0] FRAME_LAST = 5'h0f;
  // Converter code field inside the left-justified frame.
  localparam int CODE_BITS = 10;
  localparam int CODE_HI = 15;
  localparam int CODE_LO = 6;
  // Reset values.
  localparam logic [9:0] CODE_RST = 10'h000;
  localparam logic [15:0] WORD_RST = 16'h0000;
  localparam logic [4:0] CNT_RST = 5'h00;
  // Synchroniser reset levels: chip select idles high, the rest low.
  localparam logic [3:0] PIN_RST = 4'h4;
  // Number of pins passed through the synchroniser.
  localparam int PIN_COUNT = 4;
  // Frame sequencer states.
  typedef enum logic [1:0] {
    SDW_IDLE  = 2'b01,
    SDW_SHIFT = 2'b10
  } sdw_state_e;
endpackage

// *** rtl/sdw_port.sv ***
// Serial write port steering frames to the converter or command path.
// Summary of operation
// - Converter select high routes serial writes to the code register.
// - Frame bits 15..6 form code bits 9..0; lower bits discarded.
// - Converter output updates only when chip select rises after the frame.
// - Clock pulses beyond sixteen bits are tolerated and their data ignored.
// - Converter select low sends reads and writes to command registers.
`timescale 1ns/10ps
module sdw_port (
  input wire logic i_mclk, // System clock, 50 MHz.
  input wire logic i_rst, // Asynchronous reset, active high.
  input wire logic i_sclk, // Serial clock pin from the host.
  input wire logic i_cs_n, // Chip select pin, active low.
  input wire logic i_din, // Serial data input pin.
  input wire logic i_conv_sel, // Converter select pin, high for code.
  input wire logic [15:0] i_cmd_rdata, // Command register read word.
  output logic o_dout, // Serial data output pin.
  output logic o_dout_oe, // Output enable for the data output.
  output logic [9:0] o_dac_code, // Converter code driving the output.
  output logic o_dac_update, // Pulse when the code is updated.
  output logic [15:0] o_cmd_word, // Word written to the command path.
  output logic o_cmd_wr // Pulse when a command word is ready.
);
  // ****************************************************************
  // Pin synchronisation and edge detection
  // ****************************************************************
  sdw_pin_if pins ();
  logic sclk_d_r;
  logic cs_d_r;
  logic sclk_rise;
  logic sclk_fall;
  logic cs_fall;
  logic cs_rise;

  sdw_sync #(
    .WIDTH(sdw_pkg::PIN_COUNT),
    .RST_VAL(sdw_pkg::PIN_RST)
  ) u_sync (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_raw({i_sclk, i_cs_n, i_din, i_conv_sel}),
    .pins(pins)
  );

  // Delayed copies of the synchronised levels find the edges.
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      sclk_d_r <= 1'b0;
      cs_d_r <= 1'b1;
    end else begin
      sclk_d_r <= pins.sclk;
      cs_d_r <= pins.cs_n;
    end
  end

  // Edge strobes, one system clock wide.
  assign sclk_rise = pins.sclk & ~sclk_d_r;
  assign sclk_fall = ~pins.sclk & sclk_d_r;
  assign cs_fall = ~pins.cs_n & cs_d_r;
  assign cs_rise = pins.cs_n & ~cs_d_r;

  // ****************************************************************
  // Frame sequencer
  // ****************************************************************
  sdw_pkg::sdw_state_e state_r;
  logic route_conv_r;
  logic [4:0] cnt_r;
  logic [15:0] shift_r;
  logic [3:0] bit_idx;
  logic take_bit;
  logic frame_end;

  // A frame runs from chip select falling to chip select rising.
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      state_r <= sdw_pkg::SDW_IDLE;
    end else begin
      unique case (state_r)
        sdw_pkg::SDW_IDLE: begin
          if (cs_fall) begin
            state_r <= sdw_pkg::SDW_SHIFT;
          end
        end
        sdw_pkg::SDW_SHIFT: begin
          if (cs_rise) begin
            state_r <= sdw_pkg::SDW_IDLE;
          end
        end
      endcase
    end
  end

  // Bits past the sixteenth are dropped here.
  assign take_bit = (state_r == sdw_pkg::SDW_SHIFT) && sclk_rise &&
                    (cnt_r < sdw_pkg::FRAME_BITS_C);
  assign bit_idx = 4'(sdw_pkg::FRAME_LAST - cnt_r);
  assign frame_end = (state_r == sdw_pkg::SDW_SHIFT) && cs_rise &&
                     (cnt_r != sdw_pkg::CNT_RST);

  // Bits fill the frame from bit 15 downward; unsent bits stay zero.
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      shift_r <= sdw_pkg::WORD_RST;
      cnt_r <= sdw_pkg::CNT_RST;
    end else if (cs_fall) begin
      shift_r <= sdw_pkg::WORD_RST;
      cnt_r <= sdw_pkg::CNT_RST;
    end else if (take_bit) begin
      shift_r[bit_idx] <= pins.din;
      cnt_r <= cnt_r + 5'h01;
    end
  end

  // The route is taken from the converter select at the first bit.
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      route_conv_r <= 1'b0;
    end else if (cs_fall) begin
      route_conv_r <= 1'b0;
    end else if (take_bit && cnt_r == sdw_pkg::CNT_RST) begin
      route_conv_r <= pins.sel;
    end
  end

  // ****************************************************************
  // Converter code and command word outputs
  // ****************************************************************
  // The converter code changes only on chip select rising.
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_dac_code <= sdw_pkg::CODE_RST;
      o_dac_update <= 1'b0;
    end else begin
      o_dac_update <= frame_end && route_conv_r;
      if (frame_end && route_conv_r) begin
        o_dac_code <= shift_r[sdw_pkg::CODE_HI:sdw_pkg::CODE_LO];
      end
    end
  end

  // Frames sent with converter select low go to the command path.
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_cmd_word <= sdw_pkg::WORD_RST;
      o_cmd_wr <= 1'b0;
    end else begin
      o_cmd_wr <= frame_end && !route_conv_r;
      if (frame_end && !route_conv_r) begin
        o_cmd_word <= shift_r;
      end
    end
  end

  // ****************************************************************
  // Read data towards the host
  // ****************************************************************
  logic [15:0] rd_sh_r;

  // Read word loads at frame start and shifts on each falling clock.
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      rd_sh_r <= sdw_pkg::WORD_RST;
    end else if (cs_fall) begin
      rd_sh_r <= i_cmd_rdata;
    end else if (state_r == sdw_pkg::SDW_SHIFT && sclk_fall) begin
      rd_sh_r <= {rd_sh_r[14:0], 1'b0};
    end
  end

  // The output drives during a frame whenever the converter select pin is low.
  assign o_dout = rd_sh_r[15];
  assign o_dout_oe = (state_r == sdw_pkg::SDW_SHIFT) && !pins.sel;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  a_conv_update: assert property (
    @(posedge i_mclk) disable iff (i_rst)
    frame_end && route_conv_r |=> o_dac_update)
    else $error("converter code not updated at frame end");

  a_code_value: assert property (
    @(posedge i_mclk) disable iff (i_rst)
    o_dac_update |-> o_dac_code == $past(shift_r[15:6]))
    else $error("converter code not taken from bits 15 to 6");

  a_code_stable: assert property (
    @(posedge i_mclk) disable iff (i_rst)
    !cs_rise |=> $stable(o_dac_code) && !o_dac_update)
    else $error("converter code changed without chip select rising");

  a_conv_no_cmd: assert property (
    @(posedge i_mclk) disable iff (i_rst)
    frame_end && route_conv_r |=> !o_cmd_wr)
    else $error("converter frame reached the command path");

  a_cmd_route: assert property (
    @(posedge i_mclk) disable iff (i_rst)
    frame_end && !route_conv_r |=> o_cmd_wr && !o_dac_update &&
    o_cmd_word == $past(shift_r))
    else $error("command frame not delivered to the command path");

  a_extra_ignored: assert property (
    @(posedge i_mclk) disable iff (i_rst)
    sclk_rise && !cs_fall && cnt_r == 5'h10 |=> $stable(shift_r) &&
    cnt_r == 5'h10)
    else $error("bit beyond sixteen changed the frame");

  a_msb_first: assert property (
    @(posedge i_mclk) disable iff (i_rst)
    take_bit && !cs_fall && cnt_r == 5'h00 |=> shift_r[15] == $past(pins.din))
    else $error("first bit did not land in bit 15");

  a_oe_conv: assert property (
    @(posedge i_mclk) disable iff (i_rst)
    pins.sel |-> !o_dout_oe)
    else $error("data output driven during converter access");

  a_dout_hold: assert property (
    @(posedge i_mclk) disable iff (i_rst)
    !cs_fall && !sclk_fall |=> $stable(o_dout))
    else $error("data output moved without a serial clock fall");

  c_conv_write: cover property (
    @(posedge i_mclk) disable iff (i_rst) o_dac_update);
  c_cmd_write: cover property (
    @(posedge i_mclk) disable iff (i_rst) o_cmd_wr);
  c_long_frame: cover property (
    @(posedge i_mclk) disable iff (i_rst)
    sclk_rise && cnt_r == 5'h10 && route_conv_r);
endmodule

// *** rtl/sdw_sync.sv ***
// Two-stage synchroniser bank for the serial pins.
`timescale 1ns/10ps
module sdw_sync #(
  parameter int WIDTH = sdw_pkg::PIN_COUNT,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic i_mclk, // System clock.
  input wire logic i_rst, // Asynchronous reset, active high.
  input wire logic [WIDTH-1:0] i_raw, // Pin levels from outside.
  sdw_pin_if.src pins // Synchronised pin levels.
);
  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] sync_r;

  // The first stage feeds only the second stage.
  // Reset holds each pin's idle level, so no false edge follows reset.
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      meta_r <= RST_VAL;
      sync_r <= RST_VAL;
    end else begin
      meta_r <= i_raw;
      sync_r <= meta_r;
    end
  end

  // Bit order: 3 clock, 2 select low, 1 data, 0 converter select.
  assign pins.sclk = sync_r[3];
  assign pins.cs_n = sync_r[2];
  assign pins.din = sync_r[1];
  assign pins.sel = sync_r[0];
endmodule

// *** tb/sdw_host_model.sv ***
// Host model that plays the serial master for the converter write port.
`timescale 1ns/10ps
module sdw_host_model (
  input wire logic i_mclk, // System clock that paces the pins.
  output logic o_sclk, // Serial clock, still between frames.
  output logic o_cs_n, // Chip select, active low.
  output logic o_din, // Serial data towards the device.
  output logic o_sel // Converter select, high for the code path.
);
  // ********************************
  // Pin driving
  // ********************************
  // Pins start idle so the device sees no frame during reset.
  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_din = 1'b0;
    o_sel = 1'b0;
  end
  // Waits the given number of falling clock edges.
  task automatic idle(input int n);
    repeat (n) @(negedge i_mclk);
  endtask
  // Sends n bits of w, top bit first, with a 160 ns serial clock.
  task automatic frame(input logic [19:0] w, input int n, input logic sel);
    o_cs_n = 1'b0;
    idle(4);
    o_sel = sel;
    idle(4);
    for (int i = 0; i < n; i++) begin
      o_din = w[19-i];
      idle(4);
      o_sclk = 1'b1;
      idle(4);
      o_sclk = 1'b0;
    end
    // A released data line must not hold its last value.
    o_din = ~o_din;
    idle(4);
    o_cs_n = 1'b1;
    idle(8);
  endtask
endmodule

// *** tb/sdw_port_tb.sv ***
// Self-checking bench for the serial converter write port.
`timescale 1ns/10ps
module sdw_port_tb;
  logic i_mclk, i_rst, sclk, cs_n, din, sel;
  logic o_dout, o_dout_oe, o_dac_update, o_cmd_wr;
  logic [15:0] i_cmd_rdata, o_cmd_word;
  logic [9:0] o_dac_code;
  logic [16:0] exp_q[$];
  logic [16:0] note;
  logic [19:0] w;
  logic [9:0] sl = 10'h34f;
  logic rd_bit;
  int bitn = 0;
  int nb[10] = '{16, 16, 10, 20, 16, 16, 0, 16, 1, 16};
  int err_total, checks_done, seed;
  // Clock at 50 MHz.
  initial i_mclk = 1'b0;
  always #10 i_mclk = ~i_mclk;
  sdw_port uut (.i_mclk(i_mclk), .i_rst(i_rst), .i_sclk(sclk),
    .i_cs_n(cs_n), .i_din(din), .i_conv_sel(sel),
    .i_cmd_rdata(i_cmd_rdata), .o_dout(o_dout), .o_dout_oe(o_dout_oe),
    .o_dac_code(o_dac_code), .o_dac_update(o_dac_update),
    .o_cmd_word(o_cmd_word), .o_cmd_wr(o_cmd_wr));
  sdw_host_model host (.i_mclk(i_mclk), .o_sclk(sclk), .o_cs_n(cs_n),
    .o_din(din), .o_sel(sel));
  // ********************************
  // Checking and reporting
  // ********************************
  // Compares one value and reports a difference at once.
  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    checks_done++;
    if (seen !== want) begin
      err_total++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  // Prints the counts and the verdict, then ends the run.
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // Sends a frame and notes the result the device owes for it.
  task automatic send(input logic [19:0] v, input int n, input logic s);
    logic [15:0] e;
    e = v[19:4] & ~(16'hffff >> n);
    if (n > 0) begin
      exp_q.push_back(s ? {1'b1, 6'h00, e[15:6]} : {1'b0, e});
    end
    host.frame(v, n, s);
  endtask
  // Each completion pulse takes the oldest note and is compared.
  // Sampling at the falling edge keeps clear of the launching edge.
  always @(negedge i_mclk) begin
    if (o_dac_update === 1'b1 || o_cmd_wr === 1'b1) begin
      if (exp_q.size() == 0) begin
        check(16'h0001, 16'h0000);
      end else begin
        note = exp_q.pop_front();
        check({15'h0000, o_dac_update}, {15'h0000, note[16]});
        check(note[16] ? {6'h00, o_dac_code} : o_cmd_word,
          note[15:0]);
        check({15'h0000, cs_n}, 16'h0001);
      end
    end
  end
  // Each serial clock rise checks the output enable, and the read bit when converter select is low.
  always @(posedge sclk) begin
    check({15'h0000, o_dout_oe}, {15'h0000, ~sel});
    if (!sel) begin
      rd_bit = bitn < 16 ? i_cmd_rdata[4'(15 - bitn)] : 1'b0;
      check({15'h0000, o_dout}, {15'h0000, rd_bit});
    end
    bitn++;
  end
  // A new frame starts the read bit count again.
  always @(negedge cs_n) begin
    bitn = 0;
  end
  // ********************************
  // Main sequence
  // ********************************
  // Resets, then runs a table of frame lengths and routes.
  initial begin
    seed = 32'h423fe78d;
    err_total = 0;
    checks_done = 0;
    i_rst = 1'b1;
    i_cmd_rdata = 16'h0000;
    repeat (4) @(posedge i_mclk);
    @(negedge i_mclk);
    i_rst = 1'b0;
    check({15'h0000, o_dout_oe}, 16'h0000);
    check({6'h00, o_dac_code}, 16'h0000);
    host.idle(4);
    for (int t = 0; t < 10; t++) begin
      w = 20'($random(seed));
      if (t == 1) begin
        w = 20'hfffff;
      end
      i_cmd_rdata = 16'($random(seed));
      send(w, nb[t], sl[t]);
      $display("test %0d done", t);
    end
    // Bounded wait for the last answers to drain.
    for (int k = 0; k < 50 && exp_q.size() > 0; k++) begin
      @(posedge i_mclk);
    end
    check(16'(exp_q.size()), 16'h0000);
    finish_test();
  end
endmodule
